// ===== rtl/evfh_cfg.svh
// Register offsets, reset values and field positions of the event flag handler
`ifndef EVFH_CFG_SVH
`define EVFH_CFG_SVH
`define EVFH_OFS_FLAGS 4'h0
`define EVFH_OFS_ENABLE 4'h4
`define EVFH_OFS_TOP 4'h8
`define EVFH_OFS_SUMMARY 4'hc
`define EVFH_RST_FLAGS 8'h00
`define EVFH_RST_ENABLE 8'h00
`define EVFH_RST_TOP 8'hff
`define EVFH_RST_SUMMARY 2'h0
`define EVFH_CODE_NONE 8'hff
`define EVFH_SUM_HIGH 1
`define EVFH_SUM_LOW 0
`define EVFH_RESP_OKAY 2'h0
`define EVFH_RESP_SLVERR 2'h2
`define EVFH_ADDR_LSB 2
`define EVFH_ADDR_MSB 3
`endif

// ===== rtl/evfh_pkg.sv
// Types shared by the event flag handler modules
package evfh_pkg;
    typedef enum logic [1:0] {
        EVFH_W_IDLE,
        EVFH_W_RESP
    } evfh_wstate_t;
    typedef logic [7:0] evfh_byte_t;
endpackage

// ===== rtl/evfh_edge_detect.sv
// Source sampling and rising edge detection
`timescale 1ns/1ps
`default_nettype none
module evfh_edge_detect import evfh_pkg::*; #(
    parameter int N = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] src,
    output logic [N-1:0] rise
);
    logic [N-1:0] samp_ff;
    logic [N-1:0] prev_ff;
    // Sample on the system clock, then compare with the previous sample
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            samp_ff <= '0;
            prev_ff <= '0;
        end else begin
            samp_ff <= src;
            prev_ff <= samp_ff;
        end
    end
    assign rise = samp_ff & ~prev_ff;
endmodule // evfh_edge_detect
`default_nettype wire

// ===== rtl/evfh_prio.sv
// Highest pending event encoder
`timescale 1ns/1ps
`default_nettype none
`include "evfh_cfg.svh"
module evfh_prio import evfh_pkg::*; (
    input wire logic [7:0] flags,
    output logic [7:0] code
);
    always_comb begin
        code = `EVFH_CODE_NONE;
        // Lowest index first so the highest index wins
        for (int i = 0; i < 8; i++) begin
            if (flags[i]) begin
                code = 8'(i);
            end
        end
    end
endmodule // evfh_prio
`default_nettype wire

// ===== rtl/evfh_top.sv
// Event flag handler with AXI4-Lite register access
//
// Functional notes
// - One flag bit per source in an eight-bit register, bit n for source n.
// - A flag sets only on an enabled rising edge of its source.
// - Writing one to a flag bit clears it; flags read back their state.
// - Writing zero to a flag bit leaves it unchanged.
// - Sources 7..4 form the high group, sources 3..0 the low group.
// - Read-write enable register, one bit per source, resets to zero.
// - Top code register gives highest pending source, all ones when idle.
// - Summary bit 1 shows high group pending, bit 0 low group; rest zero.
// - Each group drives its own core event line.
// - Source lines are sampled on the system clock before edge detection.
// - An enabled rising source raises a core event held until software clears it.
// - Reset clears flags and summary and sets the top code to all ones.
// - Events only wake the core or feed jump-on-event; no vector jump.
// - A pending event wakes the halted core, which continues in sequence.
`timescale 1ns/1ps
`default_nettype none
`include "evfh_cfg.svh"
module evfh_top import evfh_pkg::*; #(
    parameter int N_SRC = 8
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [N_SRC-1:0] EVENT_SRC,
    output logic CORE_EVENT_LINE_A,
    output logic CORE_EVENT_LINE_B,
    output logic CORE_WAKE,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_n;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ----------------------------------------
    // Address decode helper
    // ----------------------------------------
    function automatic logic [3:0] reg_ofs(input logic [31:0] a);
        reg_ofs = {a[`EVFH_ADDR_MSB:`EVFH_ADDR_LSB], 2'h0};
    endfunction
    function automatic logic addr_ok(input logic [31:0] a);
        addr_ok = (a[31:`EVFH_ADDR_MSB+1] == '0) && (a[1:0] == 2'h0);
    endfunction

    // ----------------------------------------
    // Edge detection and priority
    // ----------------------------------------
    logic [N_SRC-1:0] rise;
    evfh_edge_detect #(.N(N_SRC)) u_edge (
        .clk(CLK),
        .rst_n(rst_n),
        .src(EVENT_SRC),
        .rise(rise)
    );

    logic [7:0] event_pending_flags_ff;
    logic [7:0] nxt_event_pending_flags;
    logic [7:0] event_source_enable_ff;
    logic [7:0] event_top_code_ff;
    logic [1:0] event_level_summary_ff;
    logic [7:0] top_code;
    evfh_prio u_prio (
        .flags(nxt_event_pending_flags),
        .code(top_code)
    );

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    evfh_wstate_t wstate_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic [7:0] clear_mask;
    logic [7:0] wr_byte;

    assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_take = S_AXI_WVALID && S_AXI_WREADY;
    assign wr_fire = (wstate_ff == EVFH_W_IDLE) && aw_held_ff && w_held_ff;
    assign wr_byte = wdata_ff[7:0];

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            awaddr_ff <= '0;
            S_AXI_AWREADY <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
            end else if (wr_fire) begin
                aw_held_ff <= 1'b0;
            end
            S_AXI_AWREADY <= !aw_held_ff && !aw_take
                && (wstate_ff == EVFH_W_IDLE);
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            w_held_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            S_AXI_WREADY <= 1'b0;
        end else begin
            if (w_take) begin
                w_held_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
            end else if (wr_fire) begin
                w_held_ff <= 1'b0;
            end
            S_AXI_WREADY <= !w_held_ff && !w_take
                && (wstate_ff == EVFH_W_IDLE);
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wstate_ff <= EVFH_W_IDLE;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `EVFH_RESP_OKAY;
        end else begin
            case (wstate_ff)
                EVFH_W_IDLE: begin
                    if (wr_fire) begin
                        wstate_ff <= EVFH_W_RESP;
                        S_AXI_BVALID <= 1'b1;
                        S_AXI_BRESP <= addr_ok(awaddr_ff)
                            ? `EVFH_RESP_OKAY : `EVFH_RESP_SLVERR;
                    end
                end
                default: begin
                    if (S_AXI_BREADY) begin
                        wstate_ff <= EVFH_W_IDLE;
                        S_AXI_BVALID <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_comb begin
        clear_mask = 8'h00;
        if (wr_fire && addr_ok(awaddr_ff) && wstrb_ff[0]
            && reg_ofs(awaddr_ff) == `EVFH_OFS_FLAGS) begin
            clear_mask = wr_byte;
        end
    end

    // Set wins over clear in the same cycle
    assign nxt_event_pending_flags = (event_pending_flags_ff & ~clear_mask)
        | (rise & event_source_enable_ff);

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            event_pending_flags_ff <= `EVFH_RST_FLAGS;
        end else begin
            event_pending_flags_ff <= nxt_event_pending_flags;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            event_source_enable_ff <= `EVFH_RST_ENABLE;
        end else if (wr_fire && addr_ok(awaddr_ff) && wstrb_ff[0]
            && reg_ofs(awaddr_ff) == `EVFH_OFS_ENABLE) begin
            event_source_enable_ff <= wr_byte;
        end
    end

    // Status mirrors follow the flags in the same edge
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            event_top_code_ff <= `EVFH_RST_TOP;
            event_level_summary_ff <= `EVFH_RST_SUMMARY;
        end else begin
            event_top_code_ff <= top_code;
            event_level_summary_ff[`EVFH_SUM_HIGH] <=
                |nxt_event_pending_flags[7:4];
            event_level_summary_ff[`EVFH_SUM_LOW] <=
                |nxt_event_pending_flags[3:0];
        end
    end

    // ----------------------------------------
    // Core event lines
    // ----------------------------------------
    // Level outputs only; no vector or program counter change
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            CORE_EVENT_LINE_A <= 1'b0;
            CORE_EVENT_LINE_B <= 1'b0;
            CORE_WAKE <= 1'b0;
        end else begin
            CORE_EVENT_LINE_A <= |nxt_event_pending_flags[7:4];
            CORE_EVENT_LINE_B <= |nxt_event_pending_flags[3:0];
            CORE_WAKE <= |nxt_event_pending_flags;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    logic ar_take;
    logic [31:0] rd_word;
    assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (reg_ofs(S_AXI_ARADDR) == `EVFH_OFS_FLAGS) begin
            rd_word = {24'h00_0000, event_pending_flags_ff};
        end else if (reg_ofs(S_AXI_ARADDR) == `EVFH_OFS_ENABLE) begin
            rd_word = {24'h00_0000, event_source_enable_ff};
        end else if (reg_ofs(S_AXI_ARADDR) == `EVFH_OFS_TOP) begin
            rd_word = {24'h00_0000, event_top_code_ff};
        end else begin
            rd_word = {30'h0000_0000, event_level_summary_ff};
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= `EVFH_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !ar_take;
            if (ar_take) begin
                S_AXI_RVALID <= 1'b1;
                if (addr_ok(S_AXI_ARADDR)) begin
                    S_AXI_RDATA <= rd_word;
                    S_AXI_RRESP <= `EVFH_RESP_OKAY;
                end else begin
                    S_AXI_RDATA <= '0;
                    S_AXI_RRESP <= `EVFH_RESP_SLVERR;
                end
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_enabled_rise(int i);
        rise[i] && event_source_enable_ff[i];
    endsequence

    a_flag_sets: assert property (@(posedge CLK) disable iff (!rst_n)
        s_enabled_rise(0) |=> event_pending_flags_ff[0])
        else $error("enabled rise did not set flag 0");
    a_set_wins: assert property (@(posedge CLK) disable iff (!rst_n)
        (rise[7] && event_source_enable_ff[7] && clear_mask[7])
        |=> event_pending_flags_ff[7])
        else $error("clear beat a new event");
    a_clear_one: assert property (@(posedge CLK) disable iff (!rst_n)
        (clear_mask[5] && !rise[5]) |=> !event_pending_flags_ff[5])
        else $error("write one did not clear flag");
    a_zero_keeps: assert property (@(posedge CLK) disable iff (!rst_n)
        (event_pending_flags_ff[2] && !clear_mask[2])
        |=> event_pending_flags_ff[2])
        else $error("flag lost without clear");
    a_no_spurious: assert property (@(posedge CLK) disable iff (!rst_n)
        (!event_pending_flags_ff[1] && !(rise[1]
        && event_source_enable_ff[1])) |=> !event_pending_flags_ff[1])
        else $error("flag set without enabled edge");
    a_idle_code: assert property (@(posedge CLK) disable iff (!rst_n)
        (event_pending_flags_ff == 8'h00) |-> (event_top_code_ff == 8'hff))
        else $error("idle code not all ones");
    a_top_rank: assert property (@(posedge CLK) disable iff (!rst_n)
        event_pending_flags_ff[7] |-> (event_top_code_ff == 8'h07))
        else $error("source 7 not ranked highest");
    a_summary_high: assert property (@(posedge CLK) disable iff (!rst_n)
        event_level_summary_ff[1] == (|event_pending_flags_ff[7:4]))
        else $error("high summary wrong");
    a_line_group: assert property (@(posedge CLK) disable iff (!rst_n)
        CORE_EVENT_LINE_B == (|event_pending_flags_ff[3:0]))
        else $error("low group line wrong");
    a_src_latency: assert property (@(posedge CLK) disable iff (!rst_n)
        ($rose(EVENT_SRC[3]) && event_source_enable_ff[3]
        && $stable(event_source_enable_ff)) |-> ##2 event_pending_flags_ff[3])
        else $error("source edge not latched in two cycles");
endmodule // evfh_top
`default_nettype wire

// ===== tb/evfh_src_model.sv
// Event source peripherals driving the handler's source lines
`timescale 1ns/1ps
`default_nettype none
module evfh_src_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] fire,
    output logic [7:0] src
);
    // -----------------------------------------------------------
    // Two-cycle high pulse per fire request, low otherwise
    // -----------------------------------------------------------
    logic [7:0] hold_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src <= 8'h00;
            hold_ff <= 8'h00;
        end else begin
            src <= fire | hold_ff;
            hold_ff <= fire;
        end
    end
endmodule // evfh_src_model
`default_nettype wire

// ===== tb/event_flag_handler_tb_top.sv
// Self-checking testbench of the event flag handler
`timescale 1ns/1ps
`default_nettype none
`include "evfh_cfg.svh"
module event_flag_handler_tb_top import evfh_pkg::*;;
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] fire;
        logic [7:0] flags;
        logic [7:0] top;
        logic [1:0] sum;
    } evfh_row_t;
    localparam logic [31:0] A_FL = {28'h0, `EVFH_OFS_FLAGS};
    localparam logic [31:0] A_EN = {28'h0, `EVFH_OFS_ENABLE};
    localparam logic [31:0] A_TP = {28'h0, `EVFH_OFS_TOP};
    localparam logic [31:0] A_SM = {28'h0, `EVFH_OFS_SUMMARY};
    logic CLK, NRST, awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [7:0] src, fire;
    logic ev_a, ev_b, wake, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int n_errors, n_compared, i;
    logic [31:0] d;
    logic [1:0] r;
    evfh_row_t rows [7];
    evfh_top evfh_top_inst (.CLK(CLK), .NRST(NRST), .EVENT_SRC(src),
        .CORE_EVENT_LINE_A(ev_a), .CORE_EVENT_LINE_B(ev_b),
        .CORE_WAKE(wake), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    evfh_src_model evfh_src_model_inst (.clk(CLK), .rst_n(NRST),
        .fire(fire), .src(src));
    always #5 CLK = ~CLK;
    // -----------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        n_errors++;
        $display("unexpected at %0t: got %h exp %h", $time, 1'b0, 1'b1);
        end_sim();
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic aw, w;
        int n;
        @(posedge CLK);
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge CLK);
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
        if (n == 50) hang();
    endtask
    task automatic rd(input logic [31:0] a);
        logic ar;
        int n;
        @(posedge CLK);
        ar = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge CLK);
            if (ar && arready) begin
                ar = 1'b0;
                arvalid <= 1'b0;
            end
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n == 50) hang();
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge CLK);
        fire <= m;
        @(posedge CLK);
        fire <= 8'h00;
        repeat (5) @(posedge CLK);
    endtask
    task automatic state(input logic [7:0] fl, input logic [7:0] tp,
                         input logic [1:0] sm);
        rd(A_FL);
        chk(d, {24'h0, fl});
        rd(A_TP);
        chk(d, {24'h0, tp});
        rd(A_SM);
        chk(d, {30'h0, sm});
        @(negedge CLK);
        chk({29'h0, ev_a, ev_b, wake}, {29'h0, sm, |fl});
    endtask
    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        rows = '{'{8'hff, 8'h01, 8'h01, 8'h00, 2'h1},
                 '{8'hff, 8'h80, 8'h80, 8'h07, 2'h2},
                 '{8'hff, 8'h11, 8'h11, 8'h04, 2'h3},
                 '{8'h0f, 8'hf0, 8'h00, 8'hff, 2'h0},
                 '{8'h0f, 8'h0c, 8'h0c, 8'h03, 2'h1},
                 '{8'h20, 8'h21, 8'h20, 8'h05, 2'h2},
                 '{8'hff, 8'h42, 8'h42, 8'h06, 2'h3}};
        CLK = 1'b0;
        NRST = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
        wstrb = 4'hf;
        fire = 8'h00;
        n_errors = 0;
        n_compared = 0;
        repeat (16) @(posedge CLK);
        NRST <= 1'b1;
        repeat (4) @(posedge CLK);
        rd(A_EN);
        chk(d, 32'h0);
        state(8'h00, 8'hff, 2'h0);
        $display("test reset_values done");
        for (i = 0; i < 7; i++) begin
            wr(A_EN, {24'h0, rows[i].en});
            rd(A_EN);
            chk(d, {24'h0, rows[i].en});
            pulse(rows[i].fire);
            state(rows[i].flags, rows[i].top, rows[i].sum);
            wr(A_FL, 32'hff);
            state(8'h00, 8'hff, 2'h0);
        end
        $display("test table done");
        wr(A_EN, 32'hff);
        pulse(8'ha5);
        wr(A_FL, 32'h00);
        state(8'ha5, 8'h07, 2'h3);
        wr(A_FL, 32'h05);
        state(8'ha0, 8'h07, 2'h2);
        rd(32'h10);
        chk({30'h0, r}, {30'h0, `EVFH_RESP_SLVERR});
        chk(d, 32'h0);
        wr(32'h10, 32'hff);
        chk({30'h0, r}, {30'h0, `EVFH_RESP_SLVERR});
        wstrb <= 4'he;
        wr(A_EN, 32'h00);
        chk({30'h0, r}, {30'h0, `EVFH_RESP_OKAY});
        wstrb <= 4'hf;
        rd(A_EN);
        chk(d, 32'hff);
        $display("test selective_clear done");
        // Clear of flag 7 lands on the edge that sets it again
        @(posedge CLK);
        fire <= 8'h80;
        wr(A_FL, 32'h80);
        fire <= 8'h00;
        chk({30'h0, r}, {30'h0, `EVFH_RESP_OKAY});
        state(8'ha0, 8'h07, 2'h2);
        $display("test set_wins done");
        pulse(8'h0f);
        @(posedge CLK);
        NRST <= 1'b0;
        repeat (3) @(posedge CLK);
        NRST <= 1'b1;
        repeat (4) @(posedge CLK);
        state(8'h00, 8'hff, 2'h0);
        rd(A_EN);
        chk(d, 32'h0);
        $display("test mid_reset done");
        end_sim();
    end
endmodule // event_flag_handler_tb_top
`default_nettype wire
